/* File: include/lcu_pkg.sv */
package lcu_pkg;
  // Device register map on the register port
  localparam logic [15:0] LCU_MODE_ADDR = 16'hFF50;
  localparam logic [15:0] LCU_RXBUF_ADDR = 16'hFF51;
  localparam logic [15:0] LCU_TXBUF_ADDR = 16'hFF52;
  localparam logic [15:0] LCU_ERR_ADDR = 16'hFF53;
  localparam logic [15:0] LCU_TXST_ADDR = 16'hFF55;
  localparam logic [7:0] LCU_MODE_RST = 8'h01;
  localparam logic [7:0] LCU_BUF_RST = 8'hFF;
  localparam logic [7:0] LCU_MASK_ALL = 8'hFF;
  // Mode register fields
  localparam int LCU_PWR = 7;
  localparam int LCU_TXE = 6;
  localparam int LCU_RXE = 5;
  localparam int LCU_PS_HI = 4;
  localparam int LCU_PS_LO = 3;
  localparam int LCU_CL = 2;
  localparam int LCU_SL = 1;
  localparam int LCU_ISRM = 0;
  // Status fields
  localparam int LCU_ERR_PE = 2;
  localparam int LCU_ERR_FE = 1;
  localparam int LCU_ERR_OVE = 0;
  localparam int LCU_TXST_BF = 1;
  localparam int LCU_TXST_SF = 0;
  // Timing in reference clocks and base ticks
  localparam logic [3:0] LCU_BASE_DIV_M1 = 4'h1;
  localparam logic [3:0] LCU_BIT_TICKS_M1 = 4'hF;
  localparam logic [3:0] LCU_HALF_TICKS_M1 = 4'h7;
  localparam logic [1:0] LCU_POWER_LAG = 2'h2;
  // Controller AXI4-Lite map
  localparam logic [3:0] LCU_A_CFG = 4'h0;
  localparam logic [3:0] LCU_A_TX = 4'h4;
  localparam logic [3:0] LCU_A_RX = 4'h8;
  localparam logic [3:0] LCU_A_STAT = 4'hC;
  localparam logic [1:0] LCU_RESP_OK = 2'h0;
  localparam logic [1:0] LCU_RESP_ERR = 2'h2;
  typedef enum logic [1:0] {LCU_RX_IDLE, LCU_RX_START, LCU_RX_DATA} lcu_rx_e;
  typedef enum logic [2:0] {
    LCU_H_IDLE, LCU_H_CFG1, LCU_H_CFG2, LCU_H_CFG3,
    LCU_H_TXPOLL, LCU_H_TXWR, LCU_H_RXERR, LCU_H_RXBUF
  } lcu_host_e;
endpackage

/* File: include/lcu_if.sv */
`timescale 1ns/1ns
interface lcu_if;
  logic reg_req;
  logic reg_we;
  logic [15:0] reg_addr;
  logic [7:0] reg_wmask;
  logic [7:0] reg_wdata;
  logic reg_ack;
  logic [7:0] reg_rdata;
  logic receive_complete_irq;
  logic receive_error_irq;
  logic transmit_complete_irq;
  modport dev (
    input reg_req, reg_we, reg_addr, reg_wmask, reg_wdata,
    output reg_ack, reg_rdata, receive_complete_irq, receive_error_irq,
    transmit_complete_irq
  );
  modport host (
    output reg_req, reg_we, reg_addr, reg_wmask, reg_wdata,
    input reg_ack, reg_rdata, receive_complete_irq, receive_error_irq,
    transmit_complete_irq
  );
endinterface

/* File: rtl/lcu_uart.sv */
`timescale 1ns/1ns
// Summary of operation
// - 7-bit LSB-first: data bits 0-6, bit7 zero
// - 7-bit MSB-first: data bits 1-7, bit0 zero
// - Overrun keeps new character out of buffer
// - Receive buffer read-only, resets FFH, loads per character
// - Transmit buffer write starts sending, resets FFH
// - Buffer moves to shifter at start or frame end
// - Move and output happen on base clock tick
// - Software never writes while buffer-full set
// - Software never refreshes buffer while active
// - Mode register bit/byte writable, resets 01H
// - Power off stops clock, clears internal state
// - Power off: output high, input forced high
// - Counter runs from third base clock after power
// - Enable clear resets that direction's circuit
// - Parity: none, zero, odd, even
// - Zero parity receive never flags parity error
// - Length bit selects 7 or 8 bits
// - Stop count for transmit only; receive one
// - Route select picks error or complete interrupt
// - Power on before enables, enables off first
// - Low line at enable starts reception
// - Change format fields only while disabled
module lcu_uart (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register port and interrupts
  lcu_if.dev bus,
  // Serial link and strap
  input wire logic serial_in_pin_in,
  input wire logic msb_first_in,
  output logic serial_out_pin_out
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] rxbuf;
    logic [7:0] txbuf;
    logic [7:0] rdata;
    logic ack;
    logic [2:0] err;
    logic txbf;
    logic txsf;
    logic rx_unread;
    logic [1:0] pwr_cnt;
    logic [3:0] base_cnt;
    logic [3:0] tx_tk;
    logic [3:0] tx_left;
    logic [11:0] tx_sh;
    logic tx_out;
    logic [1:0] rx_sync;
    lcu_pkg::lcu_rx_e rx_st;
    logic [3:0] rx_tk;
    logic [3:0] rx_cnt;
    logic [7:0] rx_sh;
    logic rx_par;
    logic irq_rc;
    logic irq_re;
    logic irq_tc;
  } lcu_dev_s;

  lcu_dev_s s_r;
  lcu_dev_s s_nxt;

  // Returns {bit count, frame with start bit at bit 0}
  function automatic logic [15:0] lcu_frame(input logic [7:0] d, input logic [7:0] m,
                                            input logic msb);
    logic [7:0] sel;
    logic [11:0] f;
    logic [3:0] nb;
    logic p;
    logic pen;
    logic [3:0] cnt;
    sel = msb ? {d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]} : d;
    nb = m[lcu_pkg::LCU_CL] ? 4'h8 : 4'h7;
    p = ^(m[lcu_pkg::LCU_CL] ? sel : {1'b0, sel[6:0]});
    pen = m[lcu_pkg::LCU_PS_HI] | m[lcu_pkg::LCU_PS_LO];
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(nb)) begin
        f[i + 1] = sel[i];
      end
    end
    if (pen) begin
      // Zero, odd or even parity bit
      f[nb + 4'h1] = m[lcu_pkg::LCU_PS_HI] ? (m[lcu_pkg::LCU_PS_LO] ? p : ~p) : 1'b0;
    end
    cnt = 4'h1 + nb + {3'h0, pen} + (m[lcu_pkg::LCU_SL] ? 4'h2 : 4'h1);
    return {cnt, f};
  endfunction

  always_comb begin
    logic pwr;
    logic tk;
    logic live;
    logic rxd;
    logic bit_v;
    logic pe;
    logic fe;
    logic [3:0] nb;
    logic [15:0] fr;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.irq_rc = 1'b0;
    s_nxt.irq_re = 1'b0;
    s_nxt.irq_tc = 1'b0;
    pwr = s_r.mode[lcu_pkg::LCU_PWR];
    s_nxt.rx_sync = {s_r.rx_sync[0], serial_in_pin_in};
    rxd = pwr ? s_r.rx_sync[1] : 1'b1;
    tk = s_r.base_cnt == lcu_pkg::LCU_BASE_DIV_M1;
    s_nxt.base_cnt = tk ? 4'h0 : s_r.base_cnt + 4'h1;
    if (tk && s_r.pwr_cnt != lcu_pkg::LCU_POWER_LAG) begin
      s_nxt.pwr_cnt = s_r.pwr_cnt + 2'h1;
    end
    // Bit counters only run once the power lag has passed
    live = tk && s_r.pwr_cnt == lcu_pkg::LCU_POWER_LAG;
    fr = lcu_frame(s_r.txbuf, s_r.mode, msb_first_in);
    nb = s_r.mode[lcu_pkg::LCU_CL] ? 4'h8 : 4'h7;
    bit_v = 1'b0;
    pe = 1'b0;
    fe = 1'b0;

    // Transmit side, all moves on a base tick
    if (!s_r.mode[lcu_pkg::LCU_TXE]) begin
      s_nxt.txbf = 1'b0;
      s_nxt.txsf = 1'b0;
      s_nxt.tx_out = 1'b1;
      s_nxt.tx_tk = 4'h0;
    end else if (live) begin
      if (s_r.txsf) begin
        s_nxt.tx_tk = s_r.tx_tk + 4'h1;
        if (s_r.tx_tk == lcu_pkg::LCU_BIT_TICKS_M1) begin
          s_nxt.tx_tk = 4'h0;
          if (s_r.tx_left == 4'h1) begin
            // Next frame is loaded in the same cycle as the completion pulse goes out
            s_nxt.irq_tc = 1'b1;
            s_nxt.txsf = s_r.txbf;
            s_nxt.txbf = 1'b0;
            s_nxt.tx_out = s_r.txbf ? 1'b0 : 1'b1;
            s_nxt.tx_sh = fr[11:0] >> 1;
            s_nxt.tx_left = fr[15:12];
          end else begin
            s_nxt.tx_out = s_r.tx_sh[0];
            s_nxt.tx_sh = s_r.tx_sh >> 1;
            s_nxt.tx_left = s_r.tx_left - 4'h1;
          end
        end
      end else if (s_r.txbf) begin
        s_nxt.txbf = 1'b0;
        s_nxt.txsf = 1'b1;
        s_nxt.tx_out = 1'b0;
        s_nxt.tx_sh = fr[11:0] >> 1;
        s_nxt.tx_left = fr[15:12];
        s_nxt.tx_tk = 4'h0;
      end
    end

    // Register port; writes after transmit so a fresh write is not lost
    if (bus.reg_req) begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 8'h00;
      case (bus.reg_addr)
        lcu_pkg::LCU_MODE_ADDR: begin
          s_nxt.rdata = s_r.mode;
          if (bus.reg_we) begin
            s_nxt.mode = (s_r.mode & ~bus.reg_wmask) | (bus.reg_wdata & bus.reg_wmask);
          end
        end
        lcu_pkg::LCU_RXBUF_ADDR: begin
          s_nxt.rdata = s_r.rxbuf;
          s_nxt.rx_unread = 1'b0;
        end
        lcu_pkg::LCU_TXBUF_ADDR: begin
          s_nxt.rdata = s_r.txbuf;
          if (bus.reg_we) begin
            s_nxt.txbuf = bus.reg_wdata;
            s_nxt.txbf = pwr & s_r.mode[lcu_pkg::LCU_TXE];
          end
        end
        lcu_pkg::LCU_ERR_ADDR: begin
          s_nxt.rdata = {5'h0, s_r.err};
          s_nxt.err = 3'h0;
        end
        lcu_pkg::LCU_TXST_ADDR: begin
          s_nxt.rdata = {6'h0, s_r.txbf, s_r.txsf};
        end
        default: begin
          s_nxt.rdata = 8'h00;
        end
      endcase
    end

    // Receive side; level detect so a low line at enable starts a frame
    if (!s_r.mode[lcu_pkg::LCU_RXE]) begin
      s_nxt.rx_st = lcu_pkg::LCU_RX_IDLE;
    end else if (live) begin
      s_nxt.rx_tk = s_r.rx_tk + 4'h1;
      case (s_r.rx_st)
        lcu_pkg::LCU_RX_IDLE: begin
          s_nxt.rx_tk = 4'h0;
          if (!rxd) begin
            s_nxt.rx_st = lcu_pkg::LCU_RX_START;
          end
        end
        lcu_pkg::LCU_RX_START: begin
          if (s_r.rx_tk == lcu_pkg::LCU_HALF_TICKS_M1) begin
            s_nxt.rx_st = rxd ? lcu_pkg::LCU_RX_IDLE : lcu_pkg::LCU_RX_DATA;
            s_nxt.rx_tk = 4'h0;
            s_nxt.rx_cnt = 4'h0;
            s_nxt.rx_par = 1'b0;
          end
        end
        lcu_pkg::LCU_RX_DATA: begin
          if (s_r.rx_tk == lcu_pkg::LCU_BIT_TICKS_M1) begin
            s_nxt.rx_tk = 4'h0;
            s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
            if (s_r.rx_cnt < nb) begin
              s_nxt.rx_sh = msb_first_in ? {s_r.rx_sh[6:0], rxd} : {rxd, s_r.rx_sh[7:1]};
              s_nxt.rx_par = s_r.rx_par ^ rxd;
            end else if (s_r.rx_cnt == nb && s_r.mode[lcu_pkg::LCU_PS_HI:lcu_pkg::LCU_PS_LO] != 2'h0) begin
              s_nxt.rx_par = s_r.rx_par ^ rxd;
            end else begin
              // First stop bit ends the frame whatever the stop setting
              s_nxt.rx_st = lcu_pkg::LCU_RX_IDLE;
              fe = ~rxd;
              // Zero parity is never judged
              pe = s_r.mode[lcu_pkg::LCU_PS_HI] &
                   (s_r.mode[lcu_pkg::LCU_PS_LO] ? s_r.rx_par : ~s_r.rx_par);
              if (!s_r.rx_unread) begin
                s_nxt.rx_unread = 1'b1;
                if (s_r.mode[lcu_pkg::LCU_CL]) begin
                  s_nxt.rxbuf = s_r.rx_sh;
                end else if (msb_first_in) begin
                  s_nxt.rxbuf = {s_r.rx_sh[6:0], 1'b0};
                end else begin
                  s_nxt.rxbuf = {1'b0, s_r.rx_sh[7:1]};
                end
              end
              s_nxt.err = s_nxt.err | {pe, fe, s_r.rx_unread};
              bit_v = pe | fe | s_r.rx_unread;
              s_nxt.irq_re = bit_v & ~s_r.mode[lcu_pkg::LCU_ISRM];
              s_nxt.irq_rc = ~bit_v | s_r.mode[lcu_pkg::LCU_ISRM];
            end
          end
        end
        default: begin
          s_nxt.rx_st = lcu_pkg::LCU_RX_IDLE;
        end
      endcase
    end

    // Power off holds the operation clock and clears the internal state
    if (!pwr) begin
      s_nxt.base_cnt = 4'h0;
      s_nxt.pwr_cnt = 2'h0;
      s_nxt.err = 3'h0;
      s_nxt.txbf = 1'b0;
      s_nxt.txsf = 1'b0;
      s_nxt.rxbuf = lcu_pkg::LCU_BUF_RST;
      s_nxt.rx_unread = 1'b0;
      s_nxt.rx_st = lcu_pkg::LCU_RX_IDLE;
      s_nxt.tx_out = 1'b1;
      s_nxt.irq_rc = 1'b0;
      s_nxt.irq_re = 1'b0;
      s_nxt.irq_tc = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.mode <= lcu_pkg::LCU_MODE_RST;
      s_r.rxbuf <= lcu_pkg::LCU_BUF_RST;
      s_r.txbuf <= lcu_pkg::LCU_BUF_RST;
      s_r.tx_out <= 1'b1;
      s_r.tx_sh <= 12'hFFF;
      s_r.rx_sync <= 2'h3;
      s_r.rx_st <= lcu_pkg::LCU_RX_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign serial_out_pin_out = s_r.tx_out;
  assign bus.reg_ack = s_r.ack;
  assign bus.reg_rdata = s_r.rdata;
  assign bus.receive_complete_irq = s_r.irq_rc;
  assign bus.receive_error_irq = s_r.irq_re;
  assign bus.transmit_complete_irq = s_r.irq_tc;
endmodule

/* File: rtl/lcu_ctrl.sv */
`timescale 1ns/1ns
module lcu_ctrl (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Device register port
  lcu_if.host bus,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [3:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  typedef struct packed {
    logic awv;
    logic wv;
    logic [3:0] awaddr;
    logic [7:0] wdata;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] mode;
    logic [7:0] cfg;
    logic cfg_go;
    logic [7:0] tx_data;
    logic tx_pend;
    logic [7:0] rx_data;
    logic [2:0] rx_err;
    logic rx_valid;
    logic rx_pend;
    lcu_pkg::lcu_host_e st;
    logic busy;
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wd;
  } lcu_host_s;

  lcu_host_s s_r;
  lcu_host_s s_nxt;

  always_comb begin
    logic go;
    logic [7:0] wv8;
    s_nxt = s_r;
    s_nxt.req = 1'b0;
    go = 1'b0;
    wv8 = 8'h00;
    // AXI write channels, taken in either order
    if (s_axi_awvalid_in && s_r.awready) begin
      s_nxt.awv = 1'b1;
      s_nxt.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_r.wready) begin
      s_nxt.wv = 1'b1;
      s_nxt.wdata = s_axi_wdata_in[7:0];
    end
    if (s_r.bvalid && s_axi_bready_in) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.awv && s_r.wv && !s_r.bvalid) begin
      s_nxt.awv = 1'b0;
      s_nxt.wv = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = lcu_pkg::LCU_RESP_ERR;
      if (s_r.awaddr == lcu_pkg::LCU_A_CFG && !s_r.cfg_go) begin
        s_nxt.cfg = s_r.wdata;
        s_nxt.cfg_go = 1'b1;
        s_nxt.bresp = lcu_pkg::LCU_RESP_OK;
      end else if (s_r.awaddr == lcu_pkg::LCU_A_TX && !s_r.tx_pend) begin
        s_nxt.tx_data = s_r.wdata;
        s_nxt.tx_pend = 1'b1;
        s_nxt.bresp = lcu_pkg::LCU_RESP_OK;
      end
    end
    s_nxt.awready = ~s_nxt.awv;
    s_nxt.wready = ~s_nxt.wv;
    // AXI read channel
    if (s_r.rvalid && s_axi_rready_in) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = lcu_pkg::LCU_RESP_OK;
      case (s_axi_araddr_in)
        lcu_pkg::LCU_A_CFG: s_nxt.rdata = {24'h000000, s_r.mode};
        lcu_pkg::LCU_A_TX: s_nxt.rdata = {24'h000000, s_r.tx_data};
        lcu_pkg::LCU_A_RX: begin
          s_nxt.rdata = {20'h00000, s_r.rx_err, s_r.rx_valid, s_r.rx_data};
          s_nxt.rx_valid = 1'b0;
        end
        lcu_pkg::LCU_A_STAT: s_nxt.rdata = {29'h0000000, s_r.cfg_go, s_r.tx_pend, s_r.rx_valid};
        default: begin
          s_nxt.rdata = 32'h00000000;
          s_nxt.rresp = lcu_pkg::LCU_RESP_ERR;
        end
      endcase
    end
    s_nxt.arready = ~s_nxt.rvalid;

    // Device sequencer: one register access at a time
    if (s_r.busy && bus.reg_ack) begin
      s_nxt.busy = 1'b0;
      go = 1'b1;
    end
    case (s_r.st)
      lcu_pkg::LCU_H_IDLE: begin
        if (s_r.rx_pend) begin
          s_nxt.st = lcu_pkg::LCU_H_RXERR;
        end else if (s_r.cfg_go) begin
          s_nxt.st = lcu_pkg::LCU_H_CFG1;
        end else if (s_r.tx_pend) begin
          s_nxt.st = lcu_pkg::LCU_H_TXPOLL;
        end
      end
      // Enables drop first, power changes next, enables last
      lcu_pkg::LCU_H_CFG1: begin
        wv8 = {s_r.mode[7], 2'h0, s_r.mode[4:0]};
        if (go) begin
          s_nxt.st = lcu_pkg::LCU_H_CFG2;
        end
      end
      lcu_pkg::LCU_H_CFG2: begin
        wv8 = {s_r.cfg[7], 2'h0, s_r.cfg[4:0]};
        if (go) begin
          s_nxt.st = s_r.cfg[lcu_pkg::LCU_PWR] ? lcu_pkg::LCU_H_CFG3 : lcu_pkg::LCU_H_IDLE;
          s_nxt.cfg_go = s_r.cfg[lcu_pkg::LCU_PWR];
        end
      end
      lcu_pkg::LCU_H_CFG3: begin
        wv8 = s_r.cfg;
        if (go) begin
          s_nxt.st = lcu_pkg::LCU_H_IDLE;
          s_nxt.cfg_go = 1'b0;
        end
      end
      lcu_pkg::LCU_H_TXPOLL: begin
        if (go && !bus.reg_rdata[lcu_pkg::LCU_TXST_BF]) begin
          s_nxt.st = lcu_pkg::LCU_H_TXWR;
        end
      end
      lcu_pkg::LCU_H_TXWR: begin
        // One write per new character, never a refresh
        if (go) begin
          s_nxt.st = lcu_pkg::LCU_H_IDLE;
          s_nxt.tx_pend = 1'b0;
        end
      end
      lcu_pkg::LCU_H_RXERR: begin
        if (go) begin
          s_nxt.rx_err = bus.reg_rdata[2:0];
          s_nxt.st = lcu_pkg::LCU_H_RXBUF;
        end
      end
      lcu_pkg::LCU_H_RXBUF: begin
        if (go) begin
          s_nxt.rx_data = bus.reg_rdata;
          s_nxt.rx_valid = 1'b1;
          s_nxt.rx_pend = 1'b0;
          s_nxt.st = lcu_pkg::LCU_H_IDLE;
        end
      end
      default: s_nxt.st = lcu_pkg::LCU_H_IDLE;
    endcase
    if (s_r.st != lcu_pkg::LCU_H_IDLE && !s_r.busy && !go) begin
      s_nxt.req = 1'b1;
      s_nxt.busy = 1'b1;
      s_nxt.we = 1'b1;
      s_nxt.wd = wv8;
      case (s_r.st)
        lcu_pkg::LCU_H_TXPOLL: begin
          s_nxt.we = 1'b0;
          s_nxt.addr = lcu_pkg::LCU_TXST_ADDR;
        end
        lcu_pkg::LCU_H_TXWR: begin
          s_nxt.addr = lcu_pkg::LCU_TXBUF_ADDR;
          s_nxt.wd = s_r.tx_data;
        end
        lcu_pkg::LCU_H_RXERR: begin
          s_nxt.we = 1'b0;
          s_nxt.addr = lcu_pkg::LCU_ERR_ADDR;
        end
        lcu_pkg::LCU_H_RXBUF: begin
          s_nxt.we = 1'b0;
          s_nxt.addr = lcu_pkg::LCU_RXBUF_ADDR;
        end
        default: begin
          s_nxt.addr = lcu_pkg::LCU_MODE_ADDR;
          s_nxt.mode = wv8;
        end
      endcase
    end
    // Set wins over the clear at the buffer read
    if (bus.receive_complete_irq || bus.receive_error_irq) begin
      s_nxt.rx_pend = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
      s_r.mode <= lcu_pkg::LCU_MODE_RST;
      s_r.st <= lcu_pkg::LCU_H_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready_out = s_r.awready;
  assign s_axi_wready_out = s_r.wready;
  assign s_axi_bresp_out = s_r.bresp;
  assign s_axi_bvalid_out = s_r.bvalid;
  assign s_axi_arready_out = s_r.arready;
  assign s_axi_rdata_out = s_r.rdata;
  assign s_axi_rresp_out = s_r.rresp;
  assign s_axi_rvalid_out = s_r.rvalid;
  assign bus.reg_req = s_r.req;
  assign bus.reg_we = s_r.we;
  assign bus.reg_addr = s_r.addr;
  assign bus.reg_wmask = lcu_pkg::LCU_MASK_ALL;
  assign bus.reg_wdata = s_r.wd;
endmodule

/* File: test/lcu_link_sva.sv */
`timescale 1ns/1ns
module lcu_link_sva (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wmask,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [7:0] reg_rdata,
  // Interrupts
  input wire logic receive_complete_irq,
  input wire logic receive_error_irq,
  input wire logic transmit_complete_irq
);
  // Mode shadow rebuilt from port writes
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic pwr, txe, rxe, isrm, rd_txst;
  assign pwr = mode_r[lcu_pkg::LCU_PWR];
  assign txe = mode_r[lcu_pkg::LCU_TXE];
  assign rxe = mode_r[lcu_pkg::LCU_RXE];
  assign isrm = mode_r[lcu_pkg::LCU_ISRM];
  assign rd_txst = reg_req && !reg_we && reg_addr == lcu_pkg::LCU_TXST_ADDR;
  always_comb begin
    mode_nxt = mode_r;
    if (reg_req && reg_we && reg_addr == lcu_pkg::LCU_MODE_ADDR) begin
      mode_nxt = (mode_r & ~reg_wmask) | (reg_wdata & reg_wmask);
    end
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_r <= lcu_pkg::LCU_MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  ack_timing_a: assert property (reg_req |=> reg_ack)
    else $error("register request not acknowledged next cycle");
  ack_cause_a: assert property (reg_ack |-> $past(reg_req))
    else $error("acknowledge without request");
  // One cycle of history for the status read, two for the irq pulses, since they are registered
  txst_off_a: assert property (
    rd_txst && !pwr && !$past(pwr) |=> reg_rdata == 8'h00)
    else $error("transmit status not clear while powered down");
  irq_power_a: assert property (
    !pwr && !$past(pwr) && !$past(pwr, 2)
    |-> !(receive_complete_irq || receive_error_irq || transmit_complete_irq))
    else $error("interrupt while powered down");
  tx_quiet_a: assert property (
    !txe && !$past(txe) && !$past(txe, 2) |-> !transmit_complete_irq)
    else $error("transmit interrupt while transmit disabled");
  rx_quiet_a: assert property (
    !rxe && !$past(rxe) && !$past(rxe, 2) |-> !(receive_complete_irq || receive_error_irq))
    else $error("receive interrupt while receive disabled");
  irq_excl_a: assert property (receive_error_irq |-> !receive_complete_irq)
    else $error("both receive interrupts at once");
  err_route_a: assert property (receive_error_irq |-> !isrm)
    else $error("error interrupt despite route select");
  cover property (reg_req && reg_we);
  cover property (transmit_complete_irq);
  cover property (receive_complete_irq);
endmodule

/* File: test/lin_capable_uart_core_bench.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module lin_capable_uart_core_bench;
  logic ref_clk_in, rst_in, msb_first_in, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  wire line;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  lcu_if lnk ();
  // Loopback: the transmitter is the receiver's far node
  lcu_uart lcu_uart_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus(lnk.dev),
    .serial_in_pin_in(line), .msb_first_in(msb_first_in), .serial_out_pin_out(line));
  lcu_ctrl lcu_ctrl_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus(lnk.host),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  lcu_link_sva lcu_link_sva_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_req(lnk.reg_req), .reg_we(lnk.reg_we), .reg_addr(lnk.reg_addr),
    .reg_wmask(lnk.reg_wmask), .reg_wdata(lnk.reg_wdata), .reg_ack(lnk.reg_ack),
    .reg_rdata(lnk.reg_rdata), .receive_complete_irq(lnk.receive_complete_irq),
    .receive_error_irq(lnk.receive_error_irq),
    .transmit_complete_irq(lnk.transmit_complete_irq));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Ceiling well above the eight frames plus polling
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge ref_clk_in);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    `CHK("rresp", lcu_pkg::LCU_RESP_OK, rresp)
    rready <= 1'b0;
  endtask
  task automatic set_cfg(input logic [7:0] m);
    logic [31:0] d;
    int n;
    axi_wr(lcu_pkg::LCU_A_CFG, m, lcu_pkg::LCU_RESP_OK);
    n = 0;
    do begin
      axi_rd(lcu_pkg::LCU_A_STAT, d);
      n++;
    end while (d[2] !== 1'b0 && n < 50);
    `CHK("cfg_done", 1'b0, d[2])
  endtask
  task automatic watch(input logic [7:0] m, input int nb, input logic msb, input logic [1:0] ps,
                       input int nst);
    int n;
    n = 0;
    while (!(lnk.reg_req && lnk.reg_we && lnk.reg_addr == lcu_pkg::LCU_TXBUF_ADDR) && n < 200) begin
      @(posedge ref_clk_in);
      n++;
    end
    `CHK("tx_write", 1'b1, n < 200)
    n = 0;
    while (line !== 1'b0 && n < 40) begin
      @(posedge ref_clk_in);
      n++;
    end
    `CHK("start_lag", 1'b1, n <= 8)
    repeat (15) @(posedge ref_clk_in);
    `CHK("start", 1'b0, line)
    for (int i = 0; i < nb; i++) begin
      repeat (32) @(posedge ref_clk_in);
      `CHK("data", msb ? m[7 - i] : m[i], line)
    end
    if (ps != 2'b00) begin
      repeat (32) @(posedge ref_clk_in);
      `CHK("parity", (ps == 2'b01) ? 1'b0 : ((ps == 2'b10) ? ~^m : ^m), line)
    end
    repeat (nst) begin
      repeat (32) @(posedge ref_clk_in);
      `CHK("stop", 1'b1, line)
    end
    n = 0;
    while (lnk.transmit_complete_irq !== 1'b1 && n < 64) begin
      @(posedge ref_clk_in);
      n++;
    end
    `CHK("done_lag", 1'b1, n <= 24)
  endtask
  // Sends one character in mode cfg and checks wire (except 7-bit MSB-first) and received value under mask
  task automatic frame(input logic [7:0] cfg, input logic [7:0] d, input logic msb,
                       input logic [7:0] ex, input logic [7:0] mk);
    logic [31:0] r;
    int n;
    set_cfg(8'h80);
    @(posedge ref_clk_in);
    msb_first_in <= msb;
    set_cfg(cfg);
    fork
      axi_wr(lcu_pkg::LCU_A_TX, d, lcu_pkg::LCU_RESP_OK);
      if (!(msb && !cfg[2])) watch(cfg[2] ? d : {1'b0, d[6:0]}, cfg[2] ? 8 : 7, msb, cfg[4:3],
                                   cfg[1] ? 2 : 1);
    join
    n = 0;
    do begin
      axi_rd(lcu_pkg::LCU_A_RX, r);
      n++;
    end while (r[8] !== 1'b1 && n < 400);
    `CHK("rx_valid", 1'b1, r[8])
    `CHK("rx_data", ex & mk, r[7:0] & mk)
    `CHK("rx_err", 3'b000, r[11:9])
    $display("frame mode %0h done", cfg);
  endtask
  // Powered down: line stays high and a buffer write sends nothing
  task automatic quiet(input logic [7:0] cfg);
    int n;
    set_cfg(cfg);
    axi_wr(lcu_pkg::LCU_A_TX, 8'h33, lcu_pkg::LCU_RESP_OK);
    n = 0;
    repeat (80) begin
      @(posedge ref_clk_in);
      if (line !== 1'b1) n++;
    end
    `CHK("idle_line", 0, n)
    $display("power-down test done");
  endtask
  task automatic t_reset();
    logic [31:0] r;
    axi_rd(lcu_pkg::LCU_A_CFG, r);
    `CHK("mode_reset", 8'h01, r[7:0])
    axi_rd(lcu_pkg::LCU_A_STAT, r);
    `CHK("stat_reset", 3'b000, r[2:0])
    axi_wr(lcu_pkg::LCU_A_RX, 8'h12, lcu_pkg::LCU_RESP_ERR);
    $display("reset test done");
  endtask
  initial begin
    rst_in = 1'b1;
    msb_first_in = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h00000000;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    quiet(8'h01);
    frame(8'hE4, 8'hA5, 1'b0, 8'hA5, 8'hFF);
    frame(8'hEC, 8'h3C, 1'b0, 8'h3C, 8'hFF);
    frame(8'hF4, 8'h97, 1'b0, 8'h97, 8'hFF);
    frame(8'hFC, 8'h6B, 1'b0, 8'h6B, 8'hFF);
    frame(8'hE6, 8'hC3, 1'b0, 8'hC3, 8'hFF);
    frame(8'hE0, 8'hD5, 1'b0, 8'h55, 8'hFF);
    frame(8'hE4, 8'h81, 1'b1, 8'h81, 8'hFF);
    frame(8'hE0, 8'hB6, 1'b1, 8'h00, 8'h01);
    quiet(8'h01);
    finish_test();
  end
endmodule
